// >>> core/kbnmi_map.svh
`ifndef KBNMI_MAP_SVH
`define KBNMI_MAP_SVH
// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define KBN_ADR_DATA     8'h60
`define KBN_ADR_PORTB    8'h61
`define KBN_ADR_SCAN     8'h66
`define KBN_ADR_CTRL     8'h67
`define KBN_ADR_SHADOW   8'h68
// ----------------------------------------------------------------
// Control and status field positions
// ----------------------------------------------------------------
`define KBN_B_KEY        7
`define KBN_B_TICK       6
`define KBN_B_TRAP       5
`define KBN_B_KEYEN      3
`define KBN_B_TICKEN     2
`define KBN_B_TRAPEN     1
// ----------------------------------------------------------------
// Scan setup and control port fields
// ----------------------------------------------------------------
`define KBN_B_PRIMARY    7
`define KBN_B_MODE       2
`define KBN_B_CLKREL     6
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define KBN_RST_BYTE     8'h00
`define KBN_RST_RATE     2'h0
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define KBN_CLK_HZ       50000000
`define KBN_RATE0_HZ     51
`define KBN_RATE1_HZ     64
`define KBN_RATE2_HZ     85
`define KBN_RATE3_HZ     128
`define KBN_RX_LAST      4'h8
`endif

// >>> core/kbnmi_pkg.sv
package kbnmi_pkg;
   // Tick divider width, large enough for the slowest rate
   typedef logic [19:0] kbnmi_tick_t;

   // Whole state of the block
   typedef struct packed {
      logic        key_flag;
      logic        tick_pend;
      logic        trap_flag;
      logic        key_en;
      logic        tick_en;
      logic        trap_en;
      logic        primary;
      logic        mode;
      logic [1:0]  rate;
      logic [7:0]  portb;
      logic [7:0]  data_wr;
      logic [7:0]  rx_byte;
      logic [7:0]  rx_shift;
      logic [3:0]  rx_cnt;
      logic        clk_prev;
      kbnmi_tick_t tick_cnt;
      logic        nmi;
      logic [7:0]  rdata;
      logic        clk_hold;
   } kbnmi_state_s;
endpackage

// >>> core/kbnmi_ctrl.sv
`timescale 1ns/1ps
`include "kbnmi_map.svh"

// Contract
// R01: Tick flag shows pending tick; write-one clears it.
// R02: Trap flag shows trap NMI; write-one clears it.
// R03: Keydown enable resets low; low blocks keydown NMI. Code: low only blocks new flag sets; a set keydown flag still drives NMI.
// R04: Keydown source picked by matrix mode select.
// R05: Keydown is a level; NMI holds while present.
// R06: Keydown clear ignored while keydown still present.
// R07: Software disables keydown before clearing its flag.
// R08: Tick enable resets low; enables periodic NMIs.
// R09: Stale pending tick fires once enable is set.
// R10: Software clears tick flag before enabling ticks.
// R11: Trap NMI on control port bit6 rising write.
// R12: Clock release low drives keyboard clock low.
// R13: Handler writes diagnostic code to data port.
// R14: Primary zero: data port reads serial byte.
// R15: Primary one: data port reads written byte.
// R16: Keydown flag shows keydown NMI; write-one clears.
// R17: Rate field picks 51, 64, 85, 128 Hz.
// R18: Mode zero samples return lines, one scan lines.
// R19: NMI output is OR of active sources.
module kbnmi_ctrl
   import kbnmi_pkg::*;
#(
   parameter int unsigned MATRIX_W   = 24,
   parameter int unsigned TICK0_CYC  = `KBN_CLK_HZ / `KBN_RATE0_HZ,
   parameter int unsigned TICK1_CYC  = `KBN_CLK_HZ / `KBN_RATE1_HZ,
   parameter int unsigned TICK2_CYC  = `KBN_CLK_HZ / `KBN_RATE2_HZ,
   parameter int unsigned TICK3_CYC  = `KBN_CLK_HZ / `KBN_RATE3_HZ
) (
   // Clock and reset
   input  wire logic                clk_sys_i,
   input  wire logic                resetn_i,
   // Host I/O bus
   input  wire logic [7:0]          io_addr_i,
   input  wire logic                io_wr_i,
   input  wire logic                io_rd_i,
   input  wire logic [7:0]          io_wdata_i,
   output logic      [7:0]          io_rdata_o,
   // Keyboard matrix
   input  wire logic [MATRIX_W-1:0] matrix_scan_lines_i,
   input  wire logic [MATRIX_W-1:0] matrix_return_lines_i,
   // Serial keyboard pins
   input  wire logic                serial_kbd_clock_i,
   output logic                     serial_kbd_clock_o,
   output logic                     serial_kbd_clock_oe_o,
   input  wire logic                serial_kbd_line_i,
   // Interrupt
   output logic                     nmi_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   kbnmi_state_s st;       // Registered state
   kbnmi_state_s next_st;  // Next state
   logic         key_cond; // Keydown present now
   logic         tick_evt; // Divider wraps this cycle
   kbnmi_tick_t  tick_end; // Last count of current period
   logic         wr_ctrl;  // Write to control and status
   logic         wr_portb; // Write to keyboard control port
   logic         clk_fall; // Falling edge on serial clock

   // ----------------------------------------------------------------
   // Decode and sources
   // ----------------------------------------------------------------
   // Keydown source, level sensitive
   always_comb begin
      key_cond = st.mode ? (|matrix_scan_lines_i)    // R04 R18
                         : !(&matrix_return_lines_i);
   end

   // Period per rate; a rate change takes effect at once, in the current period
   always_comb begin
      unique case (st.rate)                              // R17
         2'h0: tick_end = kbnmi_tick_t'(TICK0_CYC - 1);
         2'h1: tick_end = kbnmi_tick_t'(TICK1_CYC - 1);
         2'h2: tick_end = kbnmi_tick_t'(TICK2_CYC - 1);
         2'h3: tick_end = kbnmi_tick_t'(TICK3_CYC - 1);
      endcase
   end

   assign tick_evt = (st.tick_cnt >= tick_end);
   assign wr_ctrl  = io_wr_i && (io_addr_i == `KBN_ADR_CTRL);
   assign wr_portb = io_wr_i && (io_addr_i == `KBN_ADR_PORTB);
   assign clk_fall = st.clk_prev && !serial_kbd_clock_i;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;

      // Divider free runs so ticks stay independent of software
      if (tick_evt) begin
         next_st.tick_cnt = '0;
      end else begin
         next_st.tick_cnt = st.tick_cnt + kbnmi_tick_t'(1);
      end

      // Control register write: enables and write-one clears
      if (wr_ctrl) begin
         next_st.key_en  = io_wdata_i[`KBN_B_KEYEN];
         next_st.tick_en = io_wdata_i[`KBN_B_TICKEN];
         next_st.trap_en = io_wdata_i[`KBN_B_TRAPEN];
         // A clear while the key is still down is ignored, even with
         // the enable low, so a held key cannot lose its flag
         if (io_wdata_i[`KBN_B_KEY] && !key_cond) begin
            next_st.key_flag = 1'b0;                     // R16 R06
         end
         if (io_wdata_i[`KBN_B_TICK]) begin
            next_st.tick_pend = 1'b0;                    // R01
         end
         if (io_wdata_i[`KBN_B_TRAP]) begin
            next_st.trap_flag = 1'b0;                    // R02
         end
      end

      // Sets come after clears, so an event in a clear cycle wins
      if (st.key_en && key_cond) begin
         next_st.key_flag = 1'b1;                        // R03 R05 R06
      end
      // Pending tick kept while disabled; it fires on enable
      if (tick_evt) begin
         next_st.tick_pend = 1'b1;                       // R08 R09
      end

      // Keyboard control port and trap on bit 6 rising
      if (wr_portb) begin
         next_st.portb = io_wdata_i;
         if (st.trap_en && io_wdata_i[`KBN_B_CLKREL]
             && !st.portb[`KBN_B_CLKREL]) begin
            next_st.trap_flag = 1'b1;                    // R11
         end
      end

      // Scan setup register
      if (io_wr_i && (io_addr_i == `KBN_ADR_SCAN)) begin
         next_st.primary = io_wdata_i[`KBN_B_PRIMARY];
         next_st.mode    = io_wdata_i[`KBN_B_MODE];
         next_st.rate    = io_wdata_i[1:0];
      end

      // Data port always latches the written byte
      if (io_wr_i && (io_addr_i == `KBN_ADR_DATA)) begin
         next_st.data_wr = io_wdata_i;
      end

      // Serial receiver: start bit then eight bits, LSB first
      next_st.clk_prev = serial_kbd_clock_i;
      if (st.clk_hold) begin
         next_st.rx_cnt = 4'h0;  // Keyboard held in reset
      end else if (clk_fall) begin
         if (st.rx_cnt == `KBN_RX_LAST) begin
            next_st.rx_byte = {serial_kbd_line_i, st.rx_shift[7:1]};
            next_st.rx_cnt  = 4'h0;
         end else begin
            if (st.rx_cnt != 4'h0) begin
               next_st.rx_shift = {serial_kbd_line_i, st.rx_shift[7:1]};
            end
            next_st.rx_cnt = st.rx_cnt + 4'h1;
         end
      end

      // Clock pin pulled low while release bit is clear
      next_st.clk_hold = !next_st.portb[`KBN_B_CLKREL];  // R12

      // NMI is the OR of the active sources
      next_st.nmi = next_st.key_flag                     // R19
                    || (next_st.tick_pend && next_st.tick_en)
                    || next_st.trap_flag;

      // Read data, one cycle after the strobe
      if (io_rd_i) begin
         unique case (io_addr_i)
            `KBN_ADR_CTRL: begin
               next_st.rdata = {st.key_flag, st.tick_pend, st.trap_flag,
                                1'b0, st.key_en, st.tick_en,
                                st.trap_en, 1'b0};
            end
            `KBN_ADR_DATA: begin
               next_st.rdata = st.primary ? st.data_wr   // R14 R15
                                          : st.rx_byte;
            end
            `KBN_ADR_SHADOW: begin
               next_st.rdata = st.primary ? st.rx_byte   // R14 R15
                                          : st.data_wr;
            end
            `KBN_ADR_PORTB: begin
               next_st.rdata = st.portb;
            end
            `KBN_ADR_SCAN: begin
               next_st.rdata = {st.primary, 4'h0, st.mode, st.rate};
            end
            default: begin
               next_st.rdata = 8'h00;  // Unmapped reads as zero
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st          <= '0;
         st.portb    <= `KBN_RST_BYTE;
         st.rate     <= `KBN_RST_RATE;
         st.clk_prev <= 1'b1;
         st.clk_hold <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign io_rdata_o            = st.rdata;
   assign nmi_o                 = st.nmi;
   assign serial_kbd_clock_oe_o = st.clk_hold;
   assign serial_kbd_clock_o    = 1'b0;  // Open drain: only drives low

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   // Host write of a clear bit
   sequence s_clr(int unsigned b);
      wr_ctrl && io_wdata_i[b];
   endsequence

   // Rising write to control port bit 6 with trap enabled
   sequence s_trap_write;
      wr_portb && st.trap_en && io_wdata_i[`KBN_B_CLKREL]
      && !st.portb[`KBN_B_CLKREL];
   endsequence

   a_key_needs_en: assert property (                             // R03
      $rose(st.key_flag) |-> $past(st.key_en))
      else $error("keydown flag rose while disabled");

   a_key_level: assert property (                                // R05
      st.key_en && key_cond |=> st.key_flag && nmi_o)
      else $error("keydown level did not hold the NMI");

   a_key_clr_block: assert property (                            // R06
      s_clr(`KBN_B_KEY) ##0 (key_cond && st.key_flag) |=> st.key_flag)
      else $error("keydown cleared while key still down");

   a_key_clr: assert property (                                  // R16
      s_clr(`KBN_B_KEY) ##0 !key_cond |=> !st.key_flag)
      else $error("keydown flag not cleared");

   a_tick_clr: assert property (                                 // R01
      s_clr(`KBN_B_TICK) ##0 !tick_evt |=> !st.tick_pend)
      else $error("tick flag not cleared");

   a_tick_stale: assert property (                               // R09
      st.tick_pend && wr_ctrl && io_wdata_i[`KBN_B_TICKEN]
      && !io_wdata_i[`KBN_B_TICK] |=> nmi_o)
      else $error("pending tick did not fire on enable");

   a_tick_gen: assert property (                                 // R08
      tick_evt |=> st.tick_pend && (st.tick_cnt == '0))
      else $error("tick wrap did not set pending");

   a_trap_set: assert property (                                 // R11
      s_trap_write |=> st.trap_flag && nmi_o)
      else $error("trap write did not raise NMI");

   a_trap_clr: assert property (                                 // R02
      // A trap set needs a port write, never in the same cycle
      s_clr(`KBN_B_TRAP) |=> !st.trap_flag)
      else $error("trap flag not cleared");

   a_clk_hold: assert property (                                 // R12
      wr_portb && !io_wdata_i[`KBN_B_CLKREL]
      |=> serial_kbd_clock_oe_o && !serial_kbd_clock_o)
      else $error("keyboard clock not held low");

   a_data_route: assert property (                               // R15
      io_rd_i && (io_addr_i == `KBN_ADR_DATA) && st.primary
      |=> io_rdata_o == $past(st.data_wr))
      else $error("data port read wrong source");

   a_nmi_or: assert property (                                   // R19
      nmi_o == (st.key_flag || st.trap_flag
                || (st.tick_pend && st.tick_en)))
      else $error("NMI is not the OR of sources");

   a_shadow_route: assert property (                             // R14
      io_rd_i && (io_addr_i == `KBN_ADR_SHADOW) && !st.primary
      |=> io_rdata_o == $past(st.data_wr))
      else $error("shadow read wrong source");

   a_trap_quiet: assert property (                               // R11
      wr_portb && !st.trap_en && !st.trap_flag |=> !st.trap_flag)
      else $error("trap raised while disabled");

   a_rx_hold: assert property (                                  // R12
      st.clk_hold |=> st.rx_cnt == 4'h0)
      else $error("receiver ran while keyboard held");

endmodule

// >>> testbench/kbnmi_kbd_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial keyboard model: sends one framed byte on request
// ----------------------------------------------------------------
module kbnmi_kbd_model #(
   parameter int unsigned HALF_NS = 200   // Half bit time, far slower than clk
) (
   // Open-drain clock level seen on the wire
   input  wire logic clk_wire_i,
   // Model drive towards the pins
   output logic      kbd_clk_low_o,
   output logic      kbd_line_o
);
   // Idle: clock released to pull-up, data line high
   initial begin
      kbd_clk_low_o = 1'b0;
      kbd_line_o    = 1'b1;
   end

   // Start bit then eight data bits, least significant first
   task automatic send(input logic [7:0] b);
      logic [8:0] frame;
      frame = {b, 1'b0};
      // Keyboard stays in reset while the host holds the clock low
      wait (clk_wire_i === 1'b1);
      for (int i = 0; i < 9; i++) begin
         kbd_line_o    = frame[i];
         #(HALF_NS);
         kbd_clk_low_o = 1'b1;
         #(HALF_NS);
         kbd_clk_low_o = 1'b0;
      end
      // Line driven back high by the model after the frame
      #(HALF_NS);
      kbd_line_o = 1'b1;
   endtask
endmodule

// >>> testbench/tb_kbnmi_ctrl.sv
`timescale 1ns/1ps
module tb_kbnmi_ctrl;
   import kbnmi_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        clk_sys_i  = 1'b0;  // 50 MHz system clock
   logic        resetn_i   = 1'b0;  // Active-low reset
   logic [7:0]  io_addr_i  = 8'h00; // Bus address
   logic        io_wr_i    = 1'b0;  // Write strobe
   logic        io_rd_i    = 1'b0;  // Read strobe
   logic [7:0]  io_wdata_i = 8'h00; // Write data
   logic [7:0]  io_rdata_o;         // Read data
   logic [23:0] scan_l     = 24'h000000; // No scan line high
   logic [23:0] ret_l      = 24'hFFFFFF; // No return line low
   logic        clk_o;              // Design clock drive value
   logic        clk_oe;             // Design pulls clock low
   logic        kbd_low;            // Model pulls clock low
   logic        kbd_line;           // Model data line
   logic        nmi_o;              // Interrupt out
   wire         clk_wire = ~((clk_oe & ~clk_o) | kbd_low); // Pull-up
   int          fails     = 0;      // Mismatches
   int          cmp_count = 0;      // Comparisons
   int          cyc       = 0;      // Cycle counter
   int          t0;                 // Tick start cycle
   int          tk[4] = '{20, 16, 12, 8}; // Shortened tick periods

   always #10 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) cyc <= cyc + 1;

   // ----------------------------------------------------------------
   // Design and keyboard model
   // ----------------------------------------------------------------
   kbnmi_ctrl #(.TICK0_CYC(20), .TICK1_CYC(16), .TICK2_CYC(12),
                .TICK3_CYC(8)) dut_u (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .io_addr_i(io_addr_i),
      .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
      .io_rdata_o(io_rdata_o), .matrix_scan_lines_i(scan_l),
      .matrix_return_lines_i(ret_l), .serial_kbd_clock_i(clk_wire),
      .serial_kbd_clock_o(clk_o), .serial_kbd_clock_oe_o(clk_oe),
      .serial_kbd_line_i(kbd_line), .nmi_o(nmi_o));

   kbnmi_kbd_model kbd_u (.clk_wire_i(clk_wire), .kbd_clk_low_o(kbd_low),
                          .kbd_line_o(kbd_line));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Closing report, shared by the sequence and the watchdog
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %0h expected %0h",
                  $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   // One-cycle write strobe; a full cycle gap before the next one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      io_addr_i  = a;
      io_wdata_i = d;
      io_wr_i    = 1'b1;
      @(negedge clk_sys_i);
      io_wr_i    = 1'b0;
   endtask

   // Data is registered, so it is valid at the following falling edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                     input logic [7:0] msk);
      @(negedge clk_sys_i);
      io_addr_i = a;
      io_rd_i   = 1'b1;
      @(negedge clk_sys_i);
      io_rd_i   = 1'b0;
      chk(io_rdata_o & msk, exp);
   endtask

   task automatic rst();
      resetn_i = 1'b0;
      idle(3);
      resetn_i = 1'b1;
   endtask

   // Bounded wait for the interrupt line to reach a level
   task automatic wait_nmi(input logic v);
      int n;
      n = 0;
      while (nmi_o !== v && n < 200) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= 200) chk(nmi_o, v);
   endtask

   // ----------------------------------------------------------------
   // Watchdog, far beyond the expected run length
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      fails++;
      give_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst();
      rd(8'h67, 8'h00, 8'hBF);
      rd(8'h61, 8'h00, 8'hFF);
      chk(clk_oe, 1'b1);
      chk(clk_o, 1'b0);
      // Stale tick pends while disabled, fires as soon as enabled
      idle(25);
      rd(8'h67, 8'h40, 8'h40);
      chk(nmi_o, 1'b0);
      wr(8'h67, 8'h04);
      chk(nmi_o, 1'b1);
      wr(8'h67, 8'h40);
      chk(nmi_o, 1'b0);
      // Keydown on a return line, mode zero
      ret_l[5] = 1'b0;
      idle(3);
      chk(nmi_o, 1'b0);
      rd(8'h67, 8'h00, 8'h80);
      wr(8'h67, 8'h08);
      idle(3);
      chk(nmi_o, 1'b1);
      rd(8'h67, 8'h88, 8'h88);
      wr(8'h67, 8'h88);
      idle(2);
      rd(8'h67, 8'h80, 8'h80);
      chk(nmi_o, 1'b1);
      wr(8'h67, 8'h00);
      wr(8'h67, 8'h80);
      rd(8'h67, 8'h80, 8'h80);
      ret_l = 24'hFFFFFF;
      wr(8'h67, 8'h80);
      chk(nmi_o, 1'b0);
      rd(8'h67, 8'h00, 8'h80);
      // Mode one: return lines ignored, scan lines count
      wr(8'h66, 8'h04);
      rd(8'h66, 8'h04, 8'hFF);
      ret_l[3] = 1'b0;
      wr(8'h67, 8'h08);
      idle(3);
      chk(nmi_o, 1'b0);
      scan_l[7] = 1'b1;
      idle(3);
      chk(nmi_o, 1'b1);
      scan_l = 24'h000000;
      ret_l  = 24'hFFFFFF;
      wr(8'h67, 8'h00);
      wr(8'h67, 8'h80);
      chk(nmi_o, 1'b0);
      // Serial byte with the serial interface primary
      wr(8'h66, 8'h00);
      wr(8'h61, 8'h40);
      chk(clk_oe, 1'b0);
      kbd_u.send(8'hA5);
      idle(3);
      rd(8'h60, 8'hA5, 8'hFF);
      wr(8'h60, 8'h3C);
      rd(8'h68, 8'h3C, 8'hFF);
      wr(8'h68, 8'hFF);
      rd(8'h68, 8'h3C, 8'hFF);
      rd(8'h70, 8'h00, 8'hFF);
      wr(8'h66, 8'h80);
      rd(8'h60, 8'h3C, 8'hFF);
      rd(8'h68, 8'hA5, 8'hFF);
      // Control port trap
      wr(8'h61, 8'h00);
      chk(clk_oe, 1'b1);
      wr(8'h61, 8'h40);
      chk(nmi_o, 1'b0);
      wr(8'h61, 8'h00);
      wr(8'h67, 8'h02);
      wr(8'h61, 8'h40);
      chk(nmi_o, 1'b1);
      rd(8'h67, 8'h22, 8'hBF);
      wr(8'h60, 8'hAA);
      rd(8'h60, 8'hAA, 8'hFF);
      wr(8'h67, 8'h22);
      chk(nmi_o, 1'b0);
      wr(8'h61, 8'h40);
      chk(nmi_o, 1'b0);
      // Tick period for every rate code, fresh divider each time
      for (int r = 0; r < 4; r++) begin
         rst();
         wr(8'h66, 8'(r));
         wr(8'h67, 8'h44);
         wait_nmi(1'b1);
         wr(8'h67, 8'h44);
         wait_nmi(1'b1);
         t0 = cyc;
         wr(8'h67, 8'h44);
         chk(nmi_o, 1'b0);
         wait_nmi(1'b1);
         chk(cyc - t0, tk[r]);
      end
      give_verdict();
   end
endmodule
